/* File: mem_cfg.svh */
// Purpose: constants for the core memory subsystem
// Assumes: one core instance per copy of the subsystem
// Notes: address ranges are a plain layout of the core memory map
`ifndef MEM_CFG_SVH
`define MEM_CFG_SVH

`define WORD_W          24
`define ADDR_W          16
`define DATA_DEPTH      256
`define BOOT_DEPTH      128
`define PROG_DEPTH_C0   768
`define PROG_DEPTH_C1   1280
// data space: RAM at 16'h0000-16'h00FF, ROM at 16'h0100-16'h01FF
`define DATA_RAM_BASE   16'h0000
`define DATA_ROM_BASE   16'h0100
`define DATA_PAGE_MASK  16'hFF00
// program space in boot mode: boot ROM at 16'h0000-16'h007F
`define BOOT_MASK       16'hFF80
`define BOOT_BASE       16'h0000
`define BOOT_RESET      1'b1

`endif

/* File: mem_pkg.sv */
// Purpose: shared types for the core memory subsystem
// Assumes: mem_cfg.svh holds the numbers
// Notes: none
`include "mem_cfg.svh"
package mem_pkg;
	typedef logic [`WORD_W-1:0] word_t;
	typedef logic [`ADDR_W-1:0] addr_t;
	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_RAM,
		SEL_ROM
	} data_sel_t;
endpackage

/* File: data_bus_if.sv */
// Purpose: one data bus between the core and a RAM/ROM pair
// Assumes: single clock
// Notes: read data is registered one cycle after the address
`timescale 1ns/1ps
interface data_bus_if;
	import mem_pkg::*;
	addr_t addr;
	logic  valid;
	logic  wr;
	word_t wdata;
	word_t rdata;
	logic  hit;
	modport core (output addr, valid, wr, wdata, input rdata, hit);
	modport mem  (input addr, valid, wr, wdata, output rdata, hit);
endinterface

/* File: data_store.sv */
// Purpose: one coefficient RAM with its factory ROM on one data bus
// Assumes: ROM contents given by a constant function
// Notes: the ROM seed only differs between the two buses
`timescale 1ns/1ps
`include "mem_cfg.svh"
module data_store #(
	parameter int         DEPTH    = `DATA_DEPTH,
	parameter logic [7:0] ROM_SEED = 8'h00
) (
	input  wire logic clk,
	input  wire logic rst,
	data_bus_if.mem   bus
);
	import mem_pkg::*;

	word_t     ram [DEPTH];
	word_t     rdata_reg;
	logic      hit_reg;
	data_sel_t sel;

	// one decode per access; RAM and ROM pages never overlap
	function automatic data_sel_t decode(input addr_t a);
		if ((a & `DATA_PAGE_MASK) == `DATA_RAM_BASE)
			return SEL_RAM;
		else if ((a & `DATA_PAGE_MASK) == `DATA_ROM_BASE)
			return SEL_ROM;
		else
			return SEL_NONE;
	endfunction

	// factory content, fixed at build time
	function automatic word_t rom_word(input logic [7:0] i);
		return {i ^ ROM_SEED, ~i, i};
	endfunction

	assign sel = decode(bus.addr);

	always_ff @(posedge clk) begin
		if (bus.valid && bus.wr && sel == SEL_RAM) begin
			ram[bus.addr[7:0]] <= bus.wdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= '0;
			hit_reg   <= 1'b0;
		end else begin
			hit_reg <= bus.valid && !bus.wr && sel != SEL_NONE;
			if (bus.valid && !bus.wr) begin
				case (sel)
					SEL_RAM: rdata_reg <= ram[bus.addr[7:0]];
					SEL_ROM: rdata_reg <= rom_word(bus.addr[7:0]);
					default: rdata_reg <= '0;
				endcase
			end else begin
				rdata_reg <= '0; // bus left quiet on a write or without a valid address
			end
		end
	end

	assign bus.rdata = rdata_reg;
	assign bus.hit   = hit_reg;
endmodule

/* File: core_memory.sv */
// Purpose: memory subsystem and boot-mode control for one signal core
// Assumes: all core signals are on clk; no pin inputs
// Notes: reads return one cycle after the address
// Functional notes
// - Second coefficient store: 256x24 single-port RAM, 16-bit address.
// - The second store's 24-bit data is read/written by ALU and switch.
// - Program RAM: 24-bit words, 768 deep on core 0, 1280 on core 1.
// - Fetch drives the program address; the address unit does on a move.
// - Only the program memory move may write program words.
// - Fetched program words go to the decode controller.
// - First data ROM drives its bus only for a valid address.
// - Second data ROM drives its bus only for a valid address.
// - 128-word boot ROM holds the loader run when an image is requested.
// - Boot code moves host words to program, coefficient RAM or DRAM.
// - A one-bit mode register chooses boot mode or normal mode.
// - The boot bit sets whenever the core reset bit is written.
// - Program RAM cannot be executed until the boot bit is cleared.
// - First coefficient store is a 256x24 RAM beside the first data ROM.
`timescale 1ns/1ps
`include "mem_cfg.svh"
module core_memory #(
	parameter int CORE_INDEX = 0
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          core_reset_bit,
	input  wire logic          mode_clear,
	input  wire mem_pkg::addr_t program_addr_bus,
	input  wire logic          fetch_valid,
	input  wire logic          program_memory_move,
	input  wire logic          move_write,
	input  wire mem_pkg::addr_t move_addr,
	input  wire mem_pkg::word_t move_wdata,
	output mem_pkg::word_t     program_data_bus,
	output mem_pkg::word_t     move_rdata,
	output logic               fetch_error,
	output logic               boot_mode,
	input  wire mem_pkg::addr_t first_data_addr_bus,
	input  wire logic          first_valid,
	input  wire logic          first_write,
	input  wire mem_pkg::word_t first_wdata,
	output mem_pkg::word_t     first_data_bus,
	output logic               first_hit,
	input  wire mem_pkg::addr_t second_data_addr_bus,
	input  wire logic          second_valid,
	input  wire logic          second_write,
	input  wire mem_pkg::word_t second_wdata,
	output mem_pkg::word_t     second_data_bus,
	output logic               second_hit
);
	import mem_pkg::*;

	localparam int PDEPTH = (CORE_INDEX == 0) ? `PROG_DEPTH_C0
	                                          : `PROG_DEPTH_C1;
	localparam int PAW    = $clog2(PDEPTH);

	word_t program_ram [PDEPTH];
	logic  boot_reg;
	word_t fetch_reg;
	word_t move_reg;
	logic  ferr_reg;
	addr_t paddr;
	logic  in_prog;
	logic  in_boot;

	data_bus_if bus_a ();
	data_bus_if bus_b ();

	assign bus_a.addr  = first_data_addr_bus;
	assign bus_a.valid = first_valid;
	assign bus_a.wr    = first_write;
	assign bus_a.wdata = first_wdata;
	assign bus_b.addr  = second_data_addr_bus;
	assign bus_b.valid = second_valid;
	assign bus_b.wr    = second_write;
	assign bus_b.wdata = second_wdata;

	data_store #(.DEPTH(`DATA_DEPTH), .ROM_SEED(8'h5A)) store_a (
		.clk (clk),
		.rst (rst),
		.bus (bus_a)
	);

	data_store #(.DEPTH(`DATA_DEPTH), .ROM_SEED(8'hA5)) store_b (
		.clk (clk),
		.rst (rst),
		.bus (bus_b)
	);

	assign first_data_bus  = bus_a.rdata;
	assign first_hit       = bus_a.hit;
	assign second_data_bus = bus_b.rdata;
	assign second_hit      = bus_b.hit;

	// boot routine contents; it polls the host FIFO and moves words out
	function automatic word_t boot_word(input logic [6:0] i);
		return {17'h0_A5A5, i};
	endfunction

	function automatic logic prog_hit(input addr_t a);
		return int'(a) < PDEPTH;
	endfunction

	// move uses the address unit, fetch uses the program address bus
	assign paddr   = program_memory_move ? move_addr : program_addr_bus;
	assign in_prog = prog_hit(paddr);
	assign in_boot = (program_addr_bus & `BOOT_MASK) == `BOOT_BASE;

	// mode bit: the core reset write sets it, the boot code clears it;
	// the set wins so a reset never leaves the core in normal mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			boot_reg <= `BOOT_RESET;
		end else if (core_reset_bit) begin
			boot_reg <= 1'b1;
		end else if (mode_clear) begin
			boot_reg <= 1'b0;
		end
	end

	assign boot_mode = boot_reg;

	// only the move path writes program words
	always_ff @(posedge clk) begin
		if (program_memory_move && move_write && in_prog) begin
			program_ram[paddr[PAW-1:0]] <= move_wdata;
		end
	end

	// fetch: boot ROM while booting, program RAM afterwards
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fetch_reg <= '0;
			ferr_reg  <= 1'b0;
		end else if (fetch_valid && !program_memory_move) begin
			if (boot_reg) begin
				fetch_reg <= in_boot ? boot_word(program_addr_bus[6:0])
				                     : '0;
				ferr_reg  <= !in_boot;
			end else begin
				fetch_reg <= in_prog ? program_ram[paddr[PAW-1:0]]
				                     : '0;
				ferr_reg  <= !in_prog;
			end
		end else begin
			ferr_reg <= 1'b0;
		end
	end

	// move read back of program words, allowed in either mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			move_reg <= '0;
		end else if (program_memory_move && !move_write) begin
			move_reg <= in_prog ? program_ram[paddr[PAW-1:0]] : '0;
		end
	end

	assign program_data_bus = fetch_reg;
	assign move_rdata       = move_reg;
	assign fetch_error      = ferr_reg;
endmodule

/* File: core_memory_checker.sv */
// Purpose: port checks for core_memory
// Assumes: one clock, async high reset
// Notes: ROM and boot fills follow the fixed patterns
`timescale 1ns/1ps
module core_memory_checker
	import mem_pkg::*;
#(
	parameter int CORE_INDEX = 0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic core_reset_bit,
	input wire logic mode_clear,
	input addr_t     program_addr_bus,
	input wire logic fetch_valid,
	input wire logic program_memory_move,
	input word_t     program_data_bus,
	input wire logic fetch_error,
	input wire logic boot_mode,
	input addr_t     first_data_addr_bus,
	input wire logic first_valid,
	input wire logic first_write,
	input word_t     first_data_bus,
	input wire logic first_hit
);
	localparam int D = CORE_INDEX ? 1280 : 768;
	logic       rd;
	logic       fe;
	logic [7:0] ai;
	logic [6:0] pa;
	assign rd = first_valid && !first_write;
	assign fe = fetch_valid && !program_memory_move;
	// captured addresses let the answer be tied to its request
	always_ff @(posedge clk) begin
		ai <= first_data_addr_bus[7:0];
		pa <= program_addr_bus[6:0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_ram; rd && first_data_addr_bus < 16'h0100 |=> first_hit;
	endproperty
	a_ram: assert property (p_ram) else $error("ram read missed");
	property p_rom; rd && first_data_addr_bus[15:8] == 8'h01 |=>
		first_hit && first_data_bus == {ai ^ 8'h5A, ~ai, ai}; endproperty
	a_rom: assert property (p_rom) else $error("rom word wrong");
	property p_miss; rd && first_data_addr_bus > 16'h01FF |=>
		!first_hit && first_data_bus == 24'h0; endproperty
	a_miss: assert property (p_miss) else $error("unmapped hit");
	property p_set; core_reset_bit |=> boot_mode; endproperty
	a_set: assert property (p_set) else $error("mode not set");
	property p_clr; mode_clear && !core_reset_bit |=> !boot_mode;
	endproperty
	a_clr: assert property (p_clr) else $error("mode not cleared");
	property p_hold; boot_mode && !mode_clear |=> boot_mode; endproperty
	a_hold: assert property (p_hold) else $error("mode lost");
	property p_boot; boot_mode && fe && program_addr_bus < 16'h0080 |=>
		program_data_bus == {17'h0A5A5, pa} && !fetch_error; endproperty
	a_boot: assert property (p_boot) else $error("boot word wrong");
	property p_nerr; !boot_mode && fe && program_addr_bus >= D |=>
		fetch_error && program_data_bus == 24'h0; endproperty
	a_nerr: assert property (p_nerr) else $error("no fetch error");
	c_rom: cover property (rd && first_data_addr_bus[8]);
	c_clr: cover property (boot_mode && mode_clear);
	c_move: cover property (program_memory_move);
endmodule
bind core_memory core_memory_checker #(.CORE_INDEX(CORE_INDEX))
	i_core_memory_checker (.*);

/* File: agu_model.sv */
// Purpose: core side of the second data bus with expected answers
// Assumes: fills all RAM first so no read sees unwritten words
// Notes: exp holds the answer due in the current cycle
`timescale 1ns/1ps
module addr_unit_model
	import mem_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	output addr_t    addr,
	output logic     valid,
	output logic     write,
	output word_t    wdata,
	output word_t    exp,
	output logic     exp_hit,
	output logic     done
);
	word_t mem [256];
	word_t pend;
	logic  ph;
	int    seed = 32'h6505;
	int    n;
	initial begin
		{addr, valid, write, wdata, exp, exp_hit, pend, ph, done} = '0;
		@(negedge rst);
		for (n = 0; n < 1000; n++) begin
			@(posedge clk);
			#1;
			exp = pend;
			exp_hit = ph;
			addr = 16'(n < 256 ? n : {$random(seed)} % 768);
			valid = n < 256 || (n < 990 && $random(seed) % 2);
			write = n < 256 || $random(seed) % 2;
			wdata = $random(seed);
			ph = valid && !write && addr < 16'h0200;
			pend = !ph ? 24'h0 : addr < 16'h0100 ? mem[addr[7:0]] :
				{addr[7:0] ^ 8'hA5, ~addr[7:0], addr[7:0]};
			if (valid && write && addr < 16'h0100)
				mem[addr[7:0]] = wdata;
		end
		done = 1;
	end
endmodule

/* File: dsp_memory_boot_mode_test.sv */
// Purpose: self-checking bench for core_memory
// Assumes: core zero, 768 program words
// Notes: second bus is exercised by addr_unit_model
`timescale 1ns/1ps
module dsp_memory_boot_mode_test;
	import mem_pkg::*;
	logic  clk = 0, rst = 1, core_reset_bit = 0, mode_clear = 0;
	logic  fetch_valid = 0, program_memory_move = 0, move_write = 0;
	logic  first_valid = 0, first_write = 0, second_valid, second_write;
	logic  fetch_error, boot_mode, first_hit, second_hit, exp_hit, done;
	addr_t program_addr_bus = 0, move_addr = 0, first_data_addr_bus = 0;
	addr_t second_data_addr_bus;
	word_t move_wdata = 0, first_wdata = 0, second_wdata, program_data_bus;
	word_t move_rdata, first_data_bus, second_data_bus, exp;
	int    err_count = 0, cmp_count = 0, i;
	always #4 clk = ~clk;
	core_memory #(.CORE_INDEX(0)) i_core_memory (.*);
	addr_unit_model i_addr_unit_model (.clk, .rst,
		.addr(second_data_addr_bus),
		.valid(second_valid), .write(second_write), .wdata(second_wdata),
		.exp, .exp_hit, .done);
	function word_t bw(int k);
		return k < 128 ? {17'h0A5A5, 7'(k)} : 24'h0;
	endfunction
	task automatic chk(string s, word_t seen, word_t want);
		cmp_count++;
		if (seen !== want) begin
			err_count++;
			$display("[ERR] %s exp %h seen %h", s, want, seen);
		end
	endtask
	task automatic pc(logic f, logic m, logic w, addr_t a, word_t d);
		@(posedge clk);
		#1;
		{fetch_valid, program_memory_move, move_write} = {f, m, w};
		{program_addr_bus, move_addr, move_wdata} = {a, a, d};
		@(posedge clk);
		#1;
		{fetch_valid, program_memory_move, move_write} = 3'h0;
	endtask
	task automatic dc(logic w, addr_t a, word_t d);
		@(posedge clk);
		#1;
		{first_valid, first_write, first_data_addr_bus, first_wdata} =
			{1'b1, w, a, d};
		@(posedge clk);
		#1;
		first_valid = 0;
	endtask
	task automatic pulse(logic r);
		@(posedge clk);
		#1;
		{core_reset_bit, mode_clear} = {r, 1'b1};
		@(posedge clk);
		#1;
		{core_reset_bit, mode_clear} = 2'h0;
	endtask
	task complete_run;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(negedge clk) if (!rst && !done) begin
		chk("second data", second_data_bus, exp);
		chk("second hit", word_t'(second_hit), word_t'(exp_hit));
	end
	initial begin
		#24000;
		err_count++;
		complete_run;
	end
	initial begin
		repeat (2) @(posedge clk);
		#1;
		rst = 0;
		chk("mode at reset", word_t'(boot_mode), 24'h1);
		for (i = 0; i < 130; i++) begin
			pc(1, 0, 0, 16'(i), 24'h0);
			chk("boot fetch", program_data_bus, bw(i));
			chk("boot error", word_t'(fetch_error), 24'(i > 127));
		end
		$display("boot fetch test done");
		pc(0, 1, 1, 16'h0000, 24'h123456);
		pc(0, 1, 1, 16'h02FF, 24'hABCDEF);
		pc(0, 0, 1, 16'h02FF, 24'h111111);
		pc(1, 0, 0, 16'h0000, 24'h0);
		chk("fetch in boot", program_data_bus, bw(0));
		pulse(0);
		chk("mode cleared", word_t'(boot_mode), 24'h0);
		pc(1, 0, 0, 16'h0000, 24'h0);
		chk("fetch ram", program_data_bus, 24'h123456);
		// move address must win over a different fetch address
		@(posedge clk);
		#1;
		{program_memory_move, move_write, move_addr} = {2'h3, 16'h0010};
		{program_addr_bus, move_wdata} = {16'h0020, 24'h654321};
		@(posedge clk);
		#1;
		{program_memory_move, move_write} = 2'h0;
		pc(1, 0, 0, 16'h0010, 24'h0);
		chk("move address", program_data_bus, 24'h654321);
		pc(1, 0, 0, 16'h0300, 24'h0);
		chk("fetch past end", word_t'(fetch_error), 24'h1);
		pc(0, 1, 0, 16'h02FF, 24'h0);
		chk("move read", move_rdata, 24'hABCDEF);
		pulse(1);
		chk("set beats clear", word_t'(boot_mode), 24'h1);
		$display("program test done");
		dc(1, 16'h00FF, 24'hC0FFEE);
		dc(1, 16'h0100, 24'h0);
		dc(0, 16'h00FF, 24'h0);
		chk("first ram", first_data_bus, 24'hC0FFEE);
		dc(0, 16'h0100, 24'h0);
		chk("first rom", first_data_bus, 24'h5AFF00);
		dc(0, 16'h0200, 24'h0);
		chk("unmapped", word_t'(first_hit), 24'h0);
		$display("first bus test done");
		wait (done);
		$display("second bus test done");
		complete_run;
	end
endmodule
